// *** pkg/dpm_pkg.sv ***
// Package for the dual-port memory block: widths, organisation codes,
// register map, field positions and reset values.
// Assumes one system clock; both memory ports are paced by enable pulses.
package dpm_pkg;

  // Array geometry: 512 locations of 9 bits
  localparam int DPM_ADDR_W = 12;
  localparam int DPM_DATA_W = 9;
  localparam int DPM_WORDS = 512;
  localparam int DPM_IDX_W = 9;
  localparam int DPM_CNT_W = 10;

  // Organisation codes of the 2-bit width select
  localparam logic [1:0] DPM_ORG_4KX1 = 2'h0;
  localparam logic [1:0] DPM_ORG_2KX2 = 2'h1;
  localparam logic [1:0] DPM_ORG_1KX4 = 2'h2;
  localparam logic [1:0] DPM_ORG_512X9 = 2'h3;

  // APB register byte offsets
  localparam logic [7:0] DPM_OFS_CTRL = 8'h00;
  localparam logic [7:0] DPM_OFS_QUEUE_ALMOST_FULL = 8'h04;
  localparam logic [7:0] DPM_OFS_QUEUE_ALMOST_EMPTY = 8'h08;
  localparam logic [7:0] DPM_OFS_STATUS = 8'h0C;

  // Control fields
  localparam int DPM_CTRL_QUEUE_BIT = 0;
  localparam int DPM_CTRL_FLUSH_BIT = 1;

  // Status fields
  localparam int DPM_ST_EMPTY_BIT = 0;
  localparam int DPM_ST_FULL_BIT = 1;
  localparam int DPM_ST_QUEUE_ALMOST_EMPTY_BIT = 2;
  localparam int DPM_ST_QUEUE_ALMOST_FULL_BIT = 3;
  localparam int DPM_ST_COUNT_LSB = 8;

  // Reset values
  localparam logic DPM_RST_QUEUE = 1'b0;
  localparam logic [DPM_CNT_W-1:0] DPM_RST_QUEUE_ALMOST_FULL = 10'h1F8;
  localparam logic [DPM_CNT_W-1:0] DPM_RST_QUEUE_ALMOST_EMPTY = 10'h008;
  localparam logic [DPM_CNT_W-1:0] DPM_CAPACITY = 10'h200;

  // One memory port request, sampled when portEdge is high
  typedef struct packed {
    logic portEdge;
    logic selectN;
    logic writeN;
    logic registeredRead;
    logic writePassthrough;
    logic [1:0] widthSelect;
    logic [DPM_ADDR_W-1:0] address;
    logic [DPM_DATA_W-1:0] writeData;
  } dpm_port_req_type;

  // Queue flags
  typedef struct packed {
    logic full;
    logic empty;
    logic almostFull;
    logic almostEmpty;
  } dpm_queue_flags_type;

endpackage

// *** design/dpm_dual_port_memory_cell.sv ***
// Dual-port 4608-bit memory cell with per-port organisation, optional
// queue controller and an APB register slave for queue configuration.
// Assumes all inputs synchronous to clk_sys; each port edge is a pulse.
`timescale 1ns/1ps

module dpm_dual_port_memory_cell
  import dpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire dpm_port_req_type portAReq,
  input wire dpm_port_req_type portBReq,
  output logic [DPM_DATA_W-1:0] portAReadData,
  output logic [DPM_DATA_W-1:0] portBReadData,
  output dpm_queue_flags_type queueFlags,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // organisation picks used address bits
  // Storage word index for an address at a given organisation
  function automatic logic [DPM_IDX_W-1:0] wordIndex(
    input logic [DPM_ADDR_W-1:0] addr,
    input logic [1:0] org
  );
    case (org)
      DPM_ORG_4KX1: wordIndex = addr[11:3];
      DPM_ORG_2KX2: wordIndex = addr[10:2];
      DPM_ORG_1KX4: wordIndex = addr[9:1];
      default: wordIndex = addr[8:0];
    endcase
  endfunction

  // little-endian lanes
  // Pick the addressed lane of a stored word, right aligned
  function automatic logic [DPM_DATA_W-1:0] laneRead(
    input logic [DPM_DATA_W-1:0] word,
    input logic [DPM_ADDR_W-1:0] addr,
    input logic [1:0] org
  );
    logic [2:0] bitSel;
    bitSel = 3'h0;
    laneRead = word;
    case (org)
      DPM_ORG_4KX1: begin
        bitSel = addr[2:0];
        laneRead = {8'h00, word[bitSel]};
      end
      DPM_ORG_2KX2: begin
        bitSel = {addr[1:0], 1'b0};
        laneRead = {7'h00, word[bitSel +: 2]};
      end
      DPM_ORG_1KX4: begin
        laneRead = addr[0] ? {5'h00, word[7:4]} : {5'h00, word[3:0]};
      end
      default: laneRead = word;
    endcase
  endfunction

  // ninth bit kept in the narrow organisations, used data bits stored; 512x9 writes all nine bits
  // Merge narrow write data into the addressed lane of a word
  function automatic logic [DPM_DATA_W-1:0] laneWrite(
    input logic [DPM_DATA_W-1:0] word,
    input logic [DPM_ADDR_W-1:0] addr,
    input logic [1:0] org,
    input logic [DPM_DATA_W-1:0] data
  );
    logic [2:0] bitSel;
    logic [DPM_DATA_W-1:0] merged;
    bitSel = 3'h0;
    merged = word;
    case (org)
      DPM_ORG_4KX1: begin
        bitSel = addr[2:0];
        merged[bitSel] = data[0];
      end
      DPM_ORG_2KX2: begin
        bitSel = {addr[1:0], 1'b0};
        merged[bitSel +: 2] = data[1:0];
      end
      DPM_ORG_1KX4: begin
        if (addr[0]) begin
          merged[7:4] = data[3:0];
        end else begin
          merged[3:0] = data[3:0];
        end
      end
      default: merged = data;
    endcase
    laneWrite = merged;
  endfunction

  // Storage; deliberately not reset so contents survive resetn
  logic [DPM_DATA_W-1:0] memArray [DPM_WORDS];

  // Configuration and queue state
  logic queueMode_reg;
  logic [DPM_CNT_W-1:0] afullLevel_reg;
  logic [DPM_CNT_W-1:0] aemptyLevel_reg;
  logic [DPM_IDX_W-1:0] wrPtr_reg;
  logic [DPM_IDX_W-1:0] rdPtr_reg;
  logic [DPM_CNT_W-1:0] count_reg;
  logic [DPM_CNT_W-1:0] count_next;
  logic flushPulse;

  // Per-port effective request after queue steering
  dpm_port_req_type req [2];
  logic [1:0] portWrite;
  logic [1:0] portRead;
  logic [1:0] effOrg [2];
  logic [DPM_ADDR_W-1:0] effAddr [2];
  logic [DPM_IDX_W-1:0] effIdx [2];

  // Read-side hold registers: first stage and registered-read stage
  logic [DPM_DATA_W-1:0] stageOne_reg [2];
  logic [DPM_DATA_W-1:0] stageTwo_reg [2];

  // Queue flag decode
  logic qFull;
  logic qEmpty;
  logic pushEvent;
  logic popEvent;

  // flags follow the stored word count
  assign qFull = (count_reg == DPM_CAPACITY);
  assign qEmpty = (count_reg == '0);
  assign queueFlags.full = qFull;
  assign queueFlags.empty = qEmpty;
  assign queueFlags.almostFull = (count_reg >= afullLevel_reg);
  assign queueFlags.almostEmpty = (count_reg <= aemptyLevel_reg);

  assign req[0] = portAReq;
  assign req[1] = portBReq;

  // Port decode; in queue mode port A only pushes and port B only pops
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      portWrite[i] = req[i].portEdge & ~req[i].selectN & ~req[i].writeN;
      portRead[i] = req[i].portEdge & ~req[i].selectN & req[i].writeN;
      effOrg[i] = req[i].widthSelect;
      effAddr[i] = req[i].address;
    end
    if (queueMode_reg) begin
      portRead[0] = 1'b0;
      portWrite[1] = 1'b0;
      portWrite[0] = portWrite[0] & ~qFull;
      portRead[1] = portRead[1] & ~qEmpty;
      effOrg[0] = DPM_ORG_512X9;
      effOrg[1] = DPM_ORG_512X9;
      effAddr[0] = {3'h0, wrPtr_reg};
      effAddr[1] = {3'h0, rdPtr_reg};
    end
    for (int i = 0; i < 2; i++) begin
      effIdx[i] = wordIndex(effAddr[i], effOrg[i]);
    end
  end

  assign pushEvent = queueMode_reg & portWrite[0];
  assign popEvent = queueMode_reg & portRead[1];

  // both ports write on their own edge pulse
  // writes are held off while reset is asserted
  // Same-word writes from both ports leave port B's value; users avoid it
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (resetn && portWrite[i]) begin
        memArray[effIdx[i]] <= laneWrite(memArray[effIdx[i]], effAddr[i],
          effOrg[i], req[i].writeData);
      end
    end
  end

  // read path and write passthrough per port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        stageOne_reg[i] <= '0;
        stageTwo_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (portRead[i]) begin
          // lane extracted at this port's width
          stageOne_reg[i] <= laneRead(memArray[effIdx[i]], effAddr[i],
            effOrg[i]);
        end else if (portWrite[i] && req[i].writePassthrough) begin
          stageOne_reg[i] <= req[i].writeData;
        end
        // Second stage advances on every read or write the port performs; queue accesses refused by mode, full or empty leave it
        if (portRead[i] || portWrite[i]) begin
          stageTwo_reg[i] <= stageOne_reg[i];
        end
      end
    end
  end

  // output choice between flow-through and registered stage
  assign portAReadData = portAReq.registeredRead ? stageTwo_reg[0] :
    stageOne_reg[0];
  assign portBReadData = portBReq.registeredRead ? stageTwo_reg[1] :
    stageOne_reg[1];

  // Stored word count; push and pop together leave it unchanged
  always_comb begin
    count_next = count_reg;
    case ({pushEvent, popEvent})
      2'b10: count_next = count_reg + 10'h001;
      2'b01: count_next = count_reg - 10'h001;
      default: count_next = count_reg;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (flushPulse || !queueMode_reg) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (pushEvent) begin
        wrPtr_reg <= wrPtr_reg + 9'h001;
      end
      if (popEvent) begin
        rdPtr_reg <= rdPtr_reg + 9'h001;
      end
      count_reg <= count_next;
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with an error
  logic apbSetup;
  logic apbWrite;
  logic addrHit;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite & addrHit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  always_comb begin
    case (paddr[7:0])
      DPM_OFS_CTRL, DPM_OFS_QUEUE_ALMOST_FULL, DPM_OFS_QUEUE_ALMOST_EMPTY, DPM_OFS_STATUS:
        addrHit = (paddr[31:8] == 24'h000000);
      default: addrHit = 1'b0;
    endcase
  end

  // Flush is a write-one pulse, never stored
  assign flushPulse = apbWrite & (paddr[7:0] == DPM_OFS_CTRL) &
    pstrb[0] & pwdata[DPM_CTRL_FLUSH_BIT];

  // Configuration registers; byte lane 0 or 0..1 per field width
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      queueMode_reg <= DPM_RST_QUEUE;
      afullLevel_reg <= DPM_RST_QUEUE_ALMOST_FULL;
      aemptyLevel_reg <= DPM_RST_QUEUE_ALMOST_EMPTY;
    end else if (apbWrite) begin
      case (paddr[7:0])
        DPM_OFS_CTRL: begin
          if (pstrb[0]) begin
            queueMode_reg <= pwdata[DPM_CTRL_QUEUE_BIT];
          end
        end
        DPM_OFS_QUEUE_ALMOST_FULL: begin
          if (pstrb[0]) begin
            afullLevel_reg[7:0] <= pwdata[7:0];
          end
          if (pstrb[1]) begin
            afullLevel_reg[9:8] <= pwdata[9:8];
          end
        end
        DPM_OFS_QUEUE_ALMOST_EMPTY: begin
          if (pstrb[0]) begin
            aemptyLevel_reg[7:0] <= pwdata[7:0];
          end
          if (pstrb[1]) begin
            aemptyLevel_reg[9:8] <= pwdata[9:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data captured in the setup phase so it stands in the access phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (apbSetup && !pwrite && !addrHit) begin
      // Offsets above the map must not alias onto the low registers
      prdata <= '0;
    end else if (apbSetup && !pwrite) begin
      prdata <= '0;
      case (paddr[7:0])
        DPM_OFS_CTRL: prdata[DPM_CTRL_QUEUE_BIT] <= queueMode_reg;
        DPM_OFS_QUEUE_ALMOST_FULL: prdata[DPM_CNT_W-1:0] <= afullLevel_reg;
        DPM_OFS_QUEUE_ALMOST_EMPTY: prdata[DPM_CNT_W-1:0] <= aemptyLevel_reg;
        DPM_OFS_STATUS: begin
          prdata[DPM_ST_EMPTY_BIT] <= qEmpty;
          prdata[DPM_ST_FULL_BIT] <= qFull;
          prdata[DPM_ST_QUEUE_ALMOST_EMPTY_BIT] <= queueFlags.almostEmpty;
          prdata[DPM_ST_QUEUE_ALMOST_FULL_BIT] <= queueFlags.almostFull;
          prdata[DPM_ST_COUNT_LSB +: DPM_CNT_W] <= count_reg;
        end
        default: prdata <= '0;
      endcase
    end
  end

endmodule

// *** bench/dpm_cell_props.sv ***
// Port checker for the dual-port memory cell.
// Assumes one clock domain and edge pulses pacing each port.
`timescale 1ns/1ps
module dpm_cell_props
  import dpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire dpm_port_req_type portAReq,
  input wire dpm_port_req_type portBReq,
  input wire logic [DPM_DATA_W-1:0] portAReadData,
  input wire logic [DPM_DATA_W-1:0] portBReadData,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic actA, actB;
  // Taken accesses only
  assign actA = portAReq.portEdge && !portAReq.selectN;
  assign actB = portBReq.portEdge && !portBReq.selectN;
  idle_hold_a: assert property (
    !actA |=> $stable(portAReadData) || $changed(portAReq.registeredRead))
    else $error("port A output moved while idle");
  b_idle_hold_a: assert property (
    !actB |=> $stable(portBReadData) || $changed(portBReq.registeredRead))
    else $error("port B output moved while idle");
  // Reset is checked while it is asserted, so no disable here
  reset_zero_a: assert property (disable iff (1'b0)
    !resetn |-> portAReadData == '0 && portBReadData == '0 && prdata == '0)
    else $error("outputs not zero in reset");
  pass_write_a: assert property (
    actA && !portAReq.writeN && portAReq.writePassthrough ##1
    !portAReq.registeredRead |-> portAReadData == $past(portAReq.writeData))
    else $error("write data not passed to port A");
  keep_write_a: assert property (
    actB && !portBReq.writeN && !portBReq.writePassthrough &&
    !portBReq.registeredRead ##1 !portBReq.registeredRead |-> $stable(portBReadData))
    else $error("port B output changed on retained write");
  pipe_delay_a: assert property (
    actA && !portAReq.writeN && portAReq.writePassthrough ##1 !actA ##1
    actA && portAReq.registeredRead |=> portAReadData == $past(portAReq.writeData, 3))
    else $error("registered stage of port A wrong");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (
    psel && penable && !pwrite && paddr > 32'hFF |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
  cover property (actA && !portAReq.writeN && portAReq.writePassthrough);
  cover property (actB && portBReq.registeredRead);
  cover property (psel && penable && pslverr);
endmodule

bind dpm_dual_port_memory_cell dpm_cell_props u_dpm_cell_props (
  .clk_sys(clk_sys), .resetn(resetn), .portAReq(portAReq),
  .portBReq(portBReq), .portAReadData(portAReadData),
  .portBReadData(portBReadData), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// *** bench/dpm_fabric_model.sv ***
// Fabric-side model that drives both memory ports.
// Assumes clk_sys is the shared port clock.
`timescale 1ns/1ps
module dpm_fabric_model
  import dpm_pkg::*;
(
  input wire logic clk_sys,
  output dpm_port_req_type portAReq,
  output dpm_port_req_type portBReq
);
  // Start with portEdge low so nothing is taken before the first send
  initial begin
    portAReq = '0;
    portBReq = '0;
  end
  // one rising-edge pulse, both ports may share it
  // callers ground unused address and data bits
  task automatic send(input dpm_port_req_type a, input dpm_port_req_type b);
    @(posedge clk_sys);
    portAReq <= a;
    portBReq <= b;
    @(posedge clk_sys);
    portAReq.portEdge <= 1'b0;
    portBReq.portEdge <= 1'b0;
  endtask
endmodule

// *** bench/dpm_dual_port_memory_cell_test.sv ***
// Bench for the dual-port memory cell: registers, queue, random traffic.
// Assumes the fabric model spaces port accesses one idle cycle apart.
`timescale 1ns/1ps
module dpm_dual_port_memory_cell_test
  import dpm_pkg::*;
;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, lfsr, r;
  logic [3:0] pstrb;
  logic [8:0] portAReadData, portBReadData, mem[512], s1[2], s2[2];
  logic pp[2];
  logic [31:0] ofs[5] = '{32'(DPM_OFS_CTRL), 32'(DPM_OFS_QUEUE_ALMOST_FULL),
    32'(DPM_OFS_QUEUE_ALMOST_EMPTY), 32'(DPM_OFS_STATUS), 32'h100};
  logic [31:0] rv[5] = '{32'h0, 32'(DPM_RST_QUEUE_ALMOST_FULL), 32'(DPM_RST_QUEUE_ALMOST_EMPTY),
    32'h5, 32'h0};
  dpm_port_req_type portAReq, portBReq, a, b, idle;
  dpm_queue_flags_type queueFlags;
  int bad_count, check_count;

  always #2 clk_sys = ~clk_sys;

  dpm_fabric_model u_dpm_fabric_model (.clk_sys(clk_sys),
    .portAReq(portAReq), .portBReq(portBReq));
  dpm_dual_port_memory_cell u_dpm_dual_port_memory_cell (.clk_sys(clk_sys),
    .resetn(resetn), .portAReq(portAReq), .portBReq(portBReq),
    .portAReadData(portAReadData), .portBReadData(portBReadData),
    .queueFlags(queueFlags), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] rnd();
    lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h0);
    return lfsr;
  endfunction
  function automatic int wid(logic [1:0] o);
    return o == 2'h3 ? 9 : 1 << o;
  endfunction
  // little-endian lane of a stored word
  function automatic int word(dpm_port_req_type q);
    return int'(q.address >> (2'h3 - q.widthSelect));
  endfunction
  function automatic int pos(dpm_port_req_type q);
    return (int'(q.address) % (8 >> q.widthSelect)) * wid(q.widthSelect);
  endfunction
  function automatic logic [8:0] lane(dpm_port_req_type q);
    return 9'((int'(mem[word(q)]) >> pos(q)) & ((1 << wid(q.widthSelect)) - 1));
  endfunction
  function automatic dpm_port_req_type mk();
    dpm_port_req_type q;
    logic [31:0] x;
    x = rnd();
    q.portEdge = 1'b1;
    q.selectN = x[2:0] == 3'h0;
    q.writeN = x[3];
    q.registeredRead = x[4];
    q.writePassthrough = x[5];
    q.widthSelect = x[7:6];
    q.address = x[19:8] & (12'hFFF >> x[7:6]);
    q.writeData = x[28:20] & ((9'h1 << wid(x[7:6])) - 9'h1);
    return q;
  endfunction
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    check_count++;
    if (x !== y) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask
  // Expected output stages: stage two follows stage one per access
  task automatic apply(input int p, inout dpm_port_req_type q, input logic [8:0] v);
    int m;
    m = ((1 << wid(q.widthSelect)) - 1) << pos(q);
    if (q.portEdge && q.selectN) q.registeredRead = pp[p];
    if (q.portEdge && !q.selectN) begin
      s2[p] = s1[p];
      if (q.writeN) s1[p] = v;
      else if (q.writePassthrough) s1[p] = q.writeData;
      if (!q.writeN) mem[word(q)] = 9'((int'(mem[word(q)]) & ~m) | (int'(q.writeData) << pos(q)));
    end
    pp[p] = q.registeredRead;
  endtask
  task automatic run();
    logic [8:0] ra, rb;
    // no same-word write from both ports
    if (!a.writeN && !b.writeN && word(a) == word(b)) b.writeN = 1'b1;
    ra = lane(a);
    rb = lane(b);
    apply(0, a, ra);
    apply(1, b, rb);
    u_dpm_fabric_model.send(a, b);
    #1;
    chk("port A data", a.registeredRead ? s2[0] : s1[0], portAReadData);
    chk("port B data", b.registeredRead ? s2[1] : s1[1], portBReadData);
  endtask
  task automatic rst();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    s1 = '{default: 9'h0};
    s2 = '{default: 9'h0};
    pp = '{default: 1'b0};
  endtask

  // A hang ends the run through the same report
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    lfsr = 32'h000151D9;
    idle = '0;
    idle.selectN = 1'b1;
    rst();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk("register", rv[i], r);
      chk("slave error", 32'(i == 4), 32'(e));
    end
    // pushes on A, pops on B, programmable threshold
    apb(1'b1, DPM_OFS_QUEUE_ALMOST_EMPTY, 32'h2);
    apb(1'b1, DPM_OFS_CTRL, 32'h1);
    // Unmapped offset reads zero even with queue mode set
    apb(1'b0, 32'h100, 32'h0);
    chk("unmapped read", 32'h0, r);
    a = idle;
    a.portEdge = 1'b1;
    a.selectN = 1'b0;
    a.widthSelect = 2'h3;
    for (int i = 0; i < 3; i++) begin
      a.writeData = 9'h1A0 + 9'(i);
      u_dpm_fabric_model.send(a, idle);
    end
    apb(1'b0, DPM_OFS_STATUS, 32'h0);
    chk("status", 32'h300, r);
    chk("flags", 32'h0, 32'(queueFlags));
    b = a;
    b.writeN = 1'b1;
    u_dpm_fabric_model.send(idle, b);
    #1;
    chk("pop", 32'h1A0, portBReadData);
    apb(1'b0, DPM_OFS_STATUS, 32'h0);
    chk("status", 32'h204, r);
    chk("flags", 32'h1, 32'(queueFlags));
    // Fill to capacity; the last push finds the queue full
    for (int i = 0; i < 511; i++) begin
      u_dpm_fabric_model.send(a, idle);
    end
    apb(1'b0, DPM_OFS_STATUS, 32'h0);
    chk("status", 32'h2000A, r);
    chk("flags", 32'hA, 32'(queueFlags));
    apb(1'b1, DPM_OFS_CTRL, 32'h0);
    rst();
    // full-width preload keeps every ninth bit known
    b = idle;
    for (int i = 0; i < DPM_WORDS; i++) begin
      a.writeData = 9'(rnd());
      a.address = 12'(i);
      run();
    end
    for (int i = 0; i < 600; i++) begin
      a = mk();
      b = mk();
      run();
    end
    rst();
    for (int i = 0; i < 32; i++) begin
      a = mk();
      a.selectN = 1'b0;
      a.writeN = 1'b1;
      b = idle;
      run();
    end
    summarize();
  end
endmodule
